// ===== inc/host_bus_cfg.svh
`ifndef HOST_BUS_CFG_SVH
`define HOST_BUS_CFG_SVH

// ==========================================================
// Clock
`define HB_CLK_MHZ 20
`define HB_SYNC_STAGES 2'd2

// ==========================================================
// Strap vector layout
`define HB_STRAP_WIDTH 6
`define HB_STRAP_SEL_MSB 2
`define HB_STRAP_SEL_LSB 0
`define HB_STRAP_ENDIAN 3
`define HB_STRAP_POWER 4
`define HB_STRAP_START 5

// ==========================================================
// Bus-select patterns
`define HB_SEL_SH_A 3'h0
`define HB_SEL_SH_B 3'h1
`define HB_SEL_68K_A 3'h3
`define HB_SEL_68K_B 3'h5
`define HB_SEL_GENERIC 3'h7

// ==========================================================
// Host window map
`define HB_BUF_LIMIT 16'ha000
`define HB_REG_BASE 16'hffe0
`define HB_REG_INDEX_MSB 4
`define HB_REV_INDEX 5'h00
`define HB_IDLE_BYTE_EN 2'h3
`define HB_ZERO_WORD 16'h0000
`define HB_ZERO_BYTE 8'h00

`endif

// ===== inc/host_bus_pkg.sv
package host_bus_pkg;

  typedef enum logic [6:0] {
    MODE_RESERVED = 7'h01,
    MODE_SH_A = 7'h02,
    MODE_SH_B = 7'h04,
    MODE_68K_A = 7'h08,
    MODE_68K_B = 7'h10,
    MODE_GEN_1 = 7'h20,
    MODE_GEN_2 = 7'h40
  } bus_mode_e;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_ACCESS = 4'h2,
    ST_ACK = 4'h4,
    ST_HOLD = 4'h8
  } host_state_e;

endpackage : host_bus_pkg

// ===== rtl/strap_sync.sv
`timescale 1ns/1ps
`default_nettype none
`include "host_bus_cfg.svh"

module strap_sync #(
  parameter int WIDTH = `HB_STRAP_WIDTH
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Pins and synchronised copy
  input wire logic [WIDTH-1:0] pinIn,
  output logic [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] next_stage1;
  logic [WIDTH-1:0] next_syncOut;

  // ==========================================================
  // Two flops per bit; first stage feeds only the second
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_comb begin
        next_stage1[i] = pinIn[i];
        next_syncOut[i] = stage1[i];
      end
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          stage1[i] <= 1'b0;
          syncOut[i] <= 1'b0;
        end else begin
          stage1[i] <= next_stage1[i];
          syncOut[i] <= next_syncOut[i];
        end
      end
    end
  endgenerate

endmodule : strap_sync

`default_nettype wire

// ===== rtl/host_bus_strap_and_decode.sv
`timescale 1ns/1ps
`default_nettype none
`include "host_bus_cfg.svh"

// Overview of operation
// - Straps captured on the third clock after reset release, then held
// - Byte-order strap low little, high big
// - Panel-power strap sets power output polarity
// - Bus-select straps and bus-start pick protocol
// - Lowest 40K of window is display buffer
// - Registers occupy top 32 bytes of window
// - Cycle ends only on acknowledge from wait
// - Index zero reads revision, repeatable
// - Wait holds host until access completes
module host_bus_strap_and_decode #(
  // Arbitrary neutral value
  parameter logic [7:0] REVISION = 8'h01
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Strap pins
  input wire logic busSelectStrap0,
  input wire logic busSelectStrap1,
  input wire logic busSelectStrap2,
  input wire logic byteOrderStrap,
  input wire logic panelPowerPolarityStrap,
  input wire logic busStartStrap,
  // Host bus
  input wire logic csN,
  input wire logic rdN,
  input wire logic [1:0] weN,
  input wire logic [15:0] addr,
  input wire logic [15:0] dataIn,
  output logic [15:0] dataOut,
  output logic dataOutEnN,
  output logic waitN,
  // Internal access port
  output logic accReq,
  output logic accIsReg,
  output logic accWrite,
  output logic [15:0] accAddr,
  output logic [1:0] accByteEn,
  output logic [15:0] accWdata,
  input wire logic accDone,
  input wire logic [15:0] accRdata,
  // Panel power and configuration
  input wire logic panelPowerOn,
  output logic panelPowerControl,
  output host_bus_pkg::bus_mode_e busMode,
  output logic bigEndian,
  output logic configured
);

  logic [`HB_STRAP_WIDTH-1:0] syncStraps;
  logic [1:0] settle;
  logic [1:0] next_settle;
  logic next_configured, next_bigEndian, next_powerActiveHigh, next_panelPowerControl;
  host_bus_pkg::bus_mode_e next_busMode;
  logic powerActiveHigh;
  host_bus_pkg::host_state_e state;
  host_bus_pkg::host_state_e next_state;
  logic isRead, next_isRead, next_accReq, next_accIsReg, next_accWrite;
  logic [15:0] next_accAddr;
  logic [1:0] next_accByteEn;
  logic [15:0] next_accWdata;
  logic [15:0] next_dataOut;
  logic next_dataOutEnN, next_waitN;
  logic start, inBuf, inReg, isRev;

  strap_sync #(.WIDTH(`HB_STRAP_WIDTH)) u_sync (
    .clk(clk),
    .resetn(resetn),
    .pinIn({busStartStrap, panelPowerPolarityStrap, byteOrderStrap,
            busSelectStrap2, busSelectStrap1, busSelectStrap0}),
    .syncOut(syncStraps)
  );

  function automatic host_bus_pkg::bus_mode_e decodeMode(input logic [2:0] sel,
                                                         input logic bs);
    case (sel)
      `HB_SEL_SH_A: decodeMode = host_bus_pkg::MODE_SH_A;
      `HB_SEL_SH_B: decodeMode = host_bus_pkg::MODE_SH_B;
      `HB_SEL_68K_A: decodeMode = host_bus_pkg::MODE_68K_A;
      `HB_SEL_68K_B: decodeMode = host_bus_pkg::MODE_68K_B;
      `HB_SEL_GENERIC: decodeMode = bs ? host_bus_pkg::MODE_GEN_2 : host_bus_pkg::MODE_GEN_1;
      default: decodeMode = host_bus_pkg::MODE_RESERVED;
    endcase
  endfunction : decodeMode

  function automatic logic [15:0] laneSwap(input logic [15:0] d, input logic swap);
    laneSwap = swap ? {d[7:0], d[15:8]} : d;
  endfunction : laneSwap

  // ==========================================================
  // Strap capture
  // Waits for the synchroniser to fill so the pins, not reset zeros, are taken
  always_comb begin
    next_settle = settle;
    next_configured = configured;
    next_busMode = busMode;
    next_bigEndian = bigEndian;
    next_powerActiveHigh = powerActiveHigh;
    if (!configured) begin
      if (settle == `HB_SYNC_STAGES) begin
        next_configured = 1'b1;
        next_busMode = decodeMode(syncStraps[`HB_STRAP_SEL_MSB:`HB_STRAP_SEL_LSB],
                                  syncStraps[`HB_STRAP_START]);
        next_bigEndian = syncStraps[`HB_STRAP_ENDIAN];
        next_powerActiveHigh = syncStraps[`HB_STRAP_POWER];
      end else begin
        next_settle = settle + 2'd1;
      end
    end
    next_panelPowerControl = powerActiveHigh ? panelPowerOn : !panelPowerOn;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      settle <= 2'd0;
      configured <= 1'b0;
      busMode <= host_bus_pkg::MODE_RESERVED;
      bigEndian <= 1'b0;
      powerActiveHigh <= 1'b0;
      panelPowerControl <= 1'b0;
    end else begin
      settle <= next_settle;
      configured <= next_configured;
      busMode <= next_busMode;
      bigEndian <= next_bigEndian;
      powerActiveHigh <= next_powerActiveHigh;
      panelPowerControl <= next_panelPowerControl;
    end
  end

  // ==========================================================
  // Host cycle
  always_comb begin
    inBuf = addr < `HB_BUF_LIMIT;
    inReg = addr >= `HB_REG_BASE;
    isRev = inReg && (addr[`HB_REG_INDEX_MSB:0] == `HB_REV_INDEX);
    start = (state == host_bus_pkg::ST_IDLE) && configured &&
            (busMode != host_bus_pkg::MODE_RESERVED) && !csN &&
            (!rdN || (weN != `HB_IDLE_BYTE_EN));
  end

  always_comb begin
    next_state = state;
    next_isRead = isRead;
    next_accReq = accReq;
    next_accIsReg = accIsReg;
    next_accWrite = accWrite;
    next_accAddr = accAddr;
    next_accByteEn = accByteEn;
    next_accWdata = accWdata;
    next_dataOut = dataOut;
    next_dataOutEnN = dataOutEnN;
    next_waitN = 1'b0;
    case (state)
      host_bus_pkg::ST_IDLE: begin
        next_dataOutEnN = 1'b1;
        if (start) begin
          next_isRead = !rdN;
          next_accWrite = rdN;
          next_accAddr = addr;
          next_accIsReg = inReg;
          next_accByteEn = rdN ? (bigEndian ? {~weN[0], ~weN[1]} : ~weN) : `HB_IDLE_BYTE_EN;
          next_accWdata = laneSwap(dataIn, bigEndian);
          if ((inBuf || inReg) && !isRev) begin
            next_accReq = 1'b1;
            next_state = host_bus_pkg::ST_ACCESS;
          end else begin
            // local revision answer; unmapped reads as zero
            next_dataOut = isRev ? laneSwap({`HB_ZERO_BYTE, REVISION}, bigEndian)
                                 : `HB_ZERO_WORD;
            next_dataOutEnN = rdN;
            next_waitN = 1'b1;
            next_state = host_bus_pkg::ST_ACK;
          end
        end
      end
      host_bus_pkg::ST_ACCESS: begin
        if (accDone) begin
          next_accReq = 1'b0;
          next_dataOut = laneSwap(accRdata, bigEndian);
          next_dataOutEnN = !isRead;
          next_waitN = 1'b1;
          next_state = host_bus_pkg::ST_ACK;
        end
      end
      host_bus_pkg::ST_ACK: begin
        next_state = host_bus_pkg::ST_HOLD;
      end
      host_bus_pkg::ST_HOLD: begin
        if (csN) begin
          next_dataOutEnN = 1'b1;
          next_state = host_bus_pkg::ST_IDLE;
        end
      end
      default: begin
        next_state = host_bus_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state <= host_bus_pkg::ST_IDLE;
      isRead <= 1'b0;
      accReq <= 1'b0;
      accIsReg <= 1'b0;
      accWrite <= 1'b0;
      accAddr <= `HB_ZERO_WORD;
      accByteEn <= `HB_IDLE_BYTE_EN;
      accWdata <= `HB_ZERO_WORD;
      dataOut <= `HB_ZERO_WORD;
      dataOutEnN <= 1'b1;
      waitN <= 1'b0;
    end else begin
      state <= next_state;
      isRead <= next_isRead;
      accReq <= next_accReq;
      accIsReg <= next_accIsReg;
      accWrite <= next_accWrite;
      accAddr <= next_accAddr;
      accByteEn <= next_accByteEn;
      accWdata <= next_accWdata;
      dataOut <= next_dataOut;
      dataOutEnN <= next_dataOutEnN;
      waitN <= next_waitN;
    end
  end

  // ==========================================================
  // Checks
  sequence cycleStart;
    start;
  endsequence

  sequence ackPulse;
    waitN ##1 !waitN;
  endsequence

  strap_capture_a: assert property (@(posedge clk) disable iff (!resetn)
    $rose(configured) |-> busMode ==
      decodeMode($past(syncStraps[`HB_STRAP_SEL_MSB:`HB_STRAP_SEL_LSB]),
                 $past(syncStraps[`HB_STRAP_START])))
    else $error("strap capture mismatch");
  config_stable_a: assert property (@(posedge clk) disable iff (!resetn)
    configured |=> $stable(busMode) && $stable(bigEndian) && $stable(powerActiveHigh))
    else $error("configuration changed after capture");
  byte_order_a: assert property (@(posedge clk) disable iff (!resetn)
    $rose(configured) |-> bigEndian == $past(syncStraps[`HB_STRAP_ENDIAN]))
    else $error("byte order not captured");
  panel_polarity_a: assert property (@(posedge clk) disable iff (!resetn)
    configured ##1 configured |-> panelPowerControl ==
      ($past(powerActiveHigh) ? $past(panelPowerOn) : !$past(panelPowerOn)))
    else $error("panel power polarity wrong");
  generic_mode_a: assert property (@(posedge clk) disable iff (!resetn)
    $rose(configured) &&
      $past(syncStraps[`HB_STRAP_SEL_MSB:`HB_STRAP_SEL_LSB]) == `HB_SEL_GENERIC &&
      !$past(syncStraps[`HB_STRAP_START])
      |-> busMode == host_bus_pkg::MODE_GEN_1)
    else $error("general mode one not selected");
  buffer_decode_a: assert property (@(posedge clk) disable iff (!resetn)
    cycleStart and (addr < `HB_BUF_LIMIT) |=> accReq && !accIsReg ##1 (accReq || waitN))
    else $error("buffer access not issued");
  reg_decode_a: assert property (@(posedge clk) disable iff (!resetn)
    cycleStart and (addr > `HB_REG_BASE) |=> accReq && accIsReg)
    else $error("register access not issued");
  revision_read_a: assert property (@(posedge clk) disable iff (!resetn)
    cycleStart and (addr == `HB_REG_BASE) and !rdN |=> ackPulse and
      (dataOut == (bigEndian ? {REVISION, 8'h00} : {8'h00, REVISION})) && !accReq)
    else $error("revision read wrong");
  wait_hold_a: assert property (@(posedge clk) disable iff (!resetn)
    accReq && !accDone |=> !waitN)
    else $error("wait released before access done");
  ack_single_a: assert property (@(posedge clk) disable iff (!resetn)
    accReq && accDone |=> ackPulse)
    else $error("acknowledge not a single pulse");

endmodule : host_bus_strap_and_decode

`default_nettype wire

// ===== tb/host_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Host processor with chip-select glue
module host_cpu_model #(
  parameter logic [9:0] BASE = 10'h001
) (
  // Clock
  input wire logic clk,
  // Bus to device
  output logic csN,
  output logic rdN,
  output logic [1:0] weN,
  output logic [15:0] addr,
  output logic [15:0] dataIn,
  input wire logic waitN,
  input wire logic [15:0] dataOut
);
  initial begin
    csN = 1'b1;
    rdN = 1'b1;
    weN = 2'h3;
    addr = 16'h0000;
    dataIn = 16'h0000;
  end

  // uncached, every access with a[31:22] equal to BASE reaches the bus
  task automatic access(input logic [31:0] a, input logic wr, input logic [1:0] be,
      input logic [15:0] d, output logic [15:0] q, output logic ack);
    ack = 1'b0;
    q = 16'h0000;
    if (a[31:22] != BASE) return;
    @(negedge clk);
    addr <= a[15:0];
    // plain 16-bit port, whole word inverted on reads
    dataIn <= wr ? d : ~d;
    @(negedge clk);
    csN <= 1'b0;
    rdN <= wr;
    weN <= wr ? ~be : 2'h3;
    // cycle ends only on high wait pulse, bounded
    for (int n = 0; n < 40 && !ack; n++) begin
      @(posedge clk);
      if (waitN === 1'b1) begin
        ack = 1'b1;
        q = dataOut;
      end
    end
    @(negedge clk);
    csN <= 1'b1;
    rdN <= 1'b1;
    weN <= 2'h3;
    dataIn <= ~dataIn;
    @(negedge clk);
  endtask : access
endmodule : host_cpu_model

`default_nettype wire

// ===== tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checkCount++; if ((g) !== (e)) begin errorCnt++; $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end

module tb_top;
  // Arbitrary value
  localparam logic [7:0] REV = 8'h5a;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [2:0] sel = 3'h7;
  logic endian = 1'b1;
  logic polarity = 1'b0;
  logic start = 1'b0;
  logic panelPowerOn = 1'b0;
  logic csN, rdN, accReq, accIsReg, accWrite, panelPowerControl, bigEndian, configured;
  logic waitN, lastReg, dataOutEnN;
  logic [15:0] memWord;
  logic [1:0] weN, accByteEn;
  logic [15:0] addr, dataIn, dataOut, accAddr, accWdata, q, w, r, a, d;
  logic accDone = 1'b0;
  logic [15:0] accRdata = 16'h0000;
  logic [15:0] coreMem [int];
  logic [15:0] refMem [int];
  host_bus_pkg::bus_mode_e busMode;
  int seed = 15;
  int errorCnt = 0;
  int checkCount = 0;

  always #25 clk = ~clk;

  host_bus_strap_and_decode #(.REVISION(REV)) DUT (.clk(clk), .resetn(resetn),
    .busSelectStrap0(sel[0]), .busSelectStrap1(sel[1]), .busSelectStrap2(sel[2]),
    .byteOrderStrap(endian), .panelPowerPolarityStrap(polarity), .busStartStrap(start),
    .csN(csN), .rdN(rdN), .weN(weN), .addr(addr), .dataIn(dataIn), .dataOut(dataOut),
    .dataOutEnN(dataOutEnN), .waitN(waitN), .accReq(accReq), .accIsReg(accIsReg),
    .accWrite(accWrite), .accAddr(accAddr), .accByteEn(accByteEn), .accWdata(accWdata),
    .accDone(accDone), .accRdata(accRdata), .panelPowerOn(panelPowerOn),
    .panelPowerControl(panelPowerControl), .busMode(busMode), .bigEndian(bigEndian),
    .configured(configured));

  host_cpu_model host (.clk(clk), .csN(csN), .rdN(rdN), .weN(weN), .addr(addr),
    .dataIn(dataIn), .waitN(waitN), .dataOut(dataOut));

  // ==========================================================
  // Core side, answers after a random stall
  always @(negedge clk) begin
    accDone <= 1'b0;
    accRdata <= ~accRdata;
    if (accReq === 1'b1 && !accDone && $random(seed) & 1) begin
      memWord = coreMem.exists(int'(accAddr)) ? coreMem[int'(accAddr)] : 16'h0000;
      if (accWrite && accByteEn[0]) memWord[7:0] = accWdata[7:0];
      if (accWrite && accByteEn[1]) memWord[15:8] = accWdata[15:8];
      if (accWrite) coreMem[int'(accAddr)] = memWord;
      accRdata <= memWord;
      accDone <= 1'b1;
      lastReg <= accIsReg;
    end
  end

  always @(negedge clk) begin
    if (resetn === 1'b1 && waitN === 1'b1) `CHK(dataOutEnN, rdN)
  end

  function automatic host_bus_pkg::bus_mode_e modeOf(logic [2:0] s, logic b);
    case (s)
      3'h0: return host_bus_pkg::MODE_SH_A;
      3'h1: return host_bus_pkg::MODE_SH_B;
      3'h3: return host_bus_pkg::MODE_68K_A;
      3'h5: return host_bus_pkg::MODE_68K_B;
      3'h7: return b ? host_bus_pkg::MODE_GEN_2 : host_bus_pkg::MODE_GEN_1;
      default: return host_bus_pkg::MODE_RESERVED;
    endcase
  endfunction : modeOf

  task automatic results;
    $display("Checks %0d errors %0d", checkCount, errorCnt);
    if (errorCnt == 0 && checkCount > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : results

  // straps set while reset is held low and kept through release
  task automatic boot(input logic [2:0] s, input logic e, input logic p, input logic b);
    @(negedge clk);
    resetn = 1'b0;
    sel = s;
    endian = e;
    polarity = p;
    start = b;
    repeat (16) @(negedge clk);
    resetn = 1'b1;
    repeat (6) @(negedge clk);
  endtask : boot

  // An acknowledge that differs from expAck, missed or unexpected, ends the run
  task automatic xfer(input logic [15:0] ad, input logic wr, input logic [1:0] be,
      input logic [15:0] dd, input logic expAck);
    logic ack;
    host.access({10'h001, seed[5:0], ad}, wr, be, dd, q, ack);
    `CHK(ack, expAck)
    if (ack !== expAck) results();
  endtask : xfer

  // ==========================================================
  // Main sequence
  initial begin
    for (int i = 0; i < 16; i++) begin
      boot(i[2:0], i[0] ^ i[3], i[1], i[3]);
      `CHK(configured, 1'b1)
      `CHK(busMode, modeOf(sel, start))
      `CHK(bigEndian, endian)
      panelPowerOn = $random(seed);
      repeat (2) @(negedge clk);
      `CHK(panelPowerControl, panelPowerOn ~^ polarity)
      sel = ~sel;
      start = ~start;
      repeat (3) @(negedge clk);
      `CHK(busMode, modeOf(~sel, ~start))
      xfer(16'hffe0, 1'b0, 2'h3, 16'h0000, modeOf(~sel, ~start) != host_bus_pkg::MODE_RESERVED);
    end
    for (int e = 1; e >= 0; e--) begin
      // bus-start low selects general mode one
      boot(3'h7, e[0], 1'b1, 1'b0);
      for (int k = 0; k < 12; k++) begin
        a = (k == 0) ? 16'h9ffe : 16'({$random(seed)} % 32'ha000) & 16'hfffe;
        d = $random(seed);
        w = (k < 2) ? 16'h3 : 16'({$random(seed)} % 3 + 1);
        xfer(a, 1'b1, w[1:0], d, 1'b1);
        `CHK(lastReg, 1'b0)
        r = refMem.exists(int'(a)) ? refMem[int'(a)] : 16'h0000;
        if (w[0]) r[7:0] = d[7:0];
        if (w[1]) r[15:8] = d[15:8];
        refMem[int'(a)] = r;
        `CHK(coreMem[int'(a)], e ? {r[7:0], r[15:8]} : r)
        xfer(a, 1'b0, 2'h3, 16'h0000, 1'b1);
        `CHK(q, r)
        xfer(16'hffe0, 1'b0, 2'h3, 16'h0000, 1'b1);
        `CHK(q, e ? {REV, 8'h00} : {8'h00, REV})
      end
      xfer(16'hffe2, 1'b1, 2'h3, 16'h1234, 1'b1);
      `CHK(lastReg, 1'b1)
      xfer(16'ha000, 1'b1, 2'h3, 16'hbeef, 1'b1);
      xfer(16'ha000, 1'b0, 2'h3, 16'h0000, 1'b1);
      `CHK(q, 16'h0000)
    end
    results();
  end
endmodule : tb_top

`default_nettype wire
